// [sim/drive_state_ctrl_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
module drive_state_ctrl_asserts (
    input wire logic                 clock,
    input wire logic                 nrst,
    input wire drive_pkg::cmd_pins_s cmd_pins,
    input wire logic                 drive_enable_n,
    input wire logic [15:0]          ramped_reference,
    input wire drive_pkg::op_state_e op_state
);
    import drive_pkg::*;
    logic live;
    // straps own the first edge after reset, priorities the rest
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst)
            live <= 1'b0;
        else
            live <= 1'b1;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    property p_fstop;
        live && cmd_pins.fstop |=> op_state == ST_FSTOP && !ramped_reference;
    endproperty
    a_fstop: assert property (p_fstop) else $error("fstop missed");
    property p_rstop;
        live && !cmd_pins.fstop && cmd_pins.rstop |=> op_state == ST_RSTOP;
    endproperty
    a_rstop: assert property (p_rstop) else $error("rstop missed");
    property p_jog_end;
        op_state == ST_JOG && cmd_pins == 4'hC |=> !ramped_reference;
    endproperty
    a_jog_end: assert property (p_jog_end) else $error("jog end");
    property p_jog_hold;
        op_state == ST_JOG && cmd_pins[2:0] == 3'h0 |=> op_state == ST_JOG;
    endproperty
    a_jog_hold: assert property (p_jog_hold) else $error("jog left");
    property p_enable;
        live && ramped_reference != 16'h0000 |=> !drive_enable_n;
    endproperty
    a_enable: assert property (p_enable) else $error("enable");
    property p_strap_run;
        // sampled nrst keeps the releasing edge itself out
        nrst && !live && cmd_pins == 4'h0 |=> op_state == ST_RUN;
    endproperty
    a_strap_run: assert property (p_strap_run) else $error("strap");
    property p_strap_none;
        nrst && !live
            && (cmd_pins[1:0] != 2'h0 || cmd_pins[3:2] == 2'h3)
            |=> op_state == ST_RSTOP;
    endproperty
    a_strap_none: assert property (p_strap_none) else $error("power");
    property p_run_latch;
        op_state == ST_RUN && cmd_pins[1:0] == 2'h0 |=> op_state == ST_RUN;
    endproperty
    a_run_latch: assert property (p_run_latch) else $error("run");
    property p_fs_latch;
        op_state == ST_FSTOP && cmd_pins == 4'hC ##1 $stable(cmd_pins)
            |-> op_state == ST_FSTOP;
    endproperty
    a_fs_latch: assert property (p_fs_latch) else $error("fstop");
endmodule
bind drive_state_ctrl drive_state_ctrl_asserts drive_state_ctrl_asserts_i (
    .clock(clock), .nrst(nrst), .cmd_pins(cmd_pins),
    .drive_enable_n(drive_enable_n), .ramped_reference(ramped_reference),
    .op_state(op_state));
`default_nettype wire

// [sim/operator_panel.sv]
`timescale 1ns/1ns
`default_nettype none
module operator_panel (
    input wire logic                 clock,
    input wire logic                 nrst,
    input wire drive_pkg::cmd_pins_s cmd_req,
    input wire logic [7:0]           lead_div,
    input wire logic [7:0]           fb_div,
    output drive_pkg::cmd_pins_s     cmd_pins,
    output logic                     lead_pulse,
    output logic                     feedback_pulse
);
    import drive_pkg::*;
    logic [7:0] lc;
    logic [7:0] fc;
    // contacts not reset, so straps are seen at release
    always_ff @(posedge clock)
        cmd_pins <= cmd_req;
    // a divider of zero parks the sensor line low
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            lc <= 8'h00;
            fc <= 8'h00;
            lead_pulse <= 1'b0;
            feedback_pulse <= 1'b0;
        end else begin
            lc <= (lc + 8'h01 >= lead_div) ? 8'h00 : lc + 8'h01;
            fc <= (fc + 8'h01 >= fb_div) ? 8'h00 : fc + 8'h01;
            if (lead_div == 8'h00)
                lead_pulse <= 1'b0;
            else if (lc + 8'h01 >= lead_div)
                lead_pulse <= !lead_pulse;
            if (fb_div == 8'h00)
                feedback_pulse <= 1'b0;
            else if (fc + 8'h01 >= fb_div)
                feedback_pulse <= !feedback_pulse;
        end
    end
endmodule
`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin \
    n_checks++; \
    if ((a) !== (e)) begin \
        err_total++; \
        $display("ERROR %0t got %0h want %0h", $time, (a), (e)); \
    end \
end
module testbench;
    import drive_pkg::*;
    logic        clock, nrst = 1'b0, awvalid = 1'b0, wvalid = 1'b0;
    logic        arvalid = 1'b0, alarm_n = 1'b1, lead_pulse, fb_pulse;
    logic        awready, wready, bvalid, arready, rvalid, enable_n;
    logic [11:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [1:0]  bresp, rresp;
    logic [7:0]  lead_div = '0, fb_div = '0;
    logic [15:0] ref_hz;
    cmd_pins_s   cmd_req = 4'hC, cmd_pins;
    select_pins_s sel = '0;
    op_state_e   op;
    int          err_total = 0, n_checks = 0, cycles = 0;
    operator_panel operator_panel_i (.clock(clock), .nrst(nrst),
        .cmd_req(cmd_req), .lead_div(lead_div), .fb_div(fb_div),
        .cmd_pins(cmd_pins), .lead_pulse(lead_pulse),
        .feedback_pulse(fb_pulse));
    drive_state_ctrl #(.WINDOW_CYCLES_P(300), .RAMP_CYCLES_P(4))
    drive_state_ctrl_i (.clock(clock), .nrst(nrst), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(1'b1), .cmd_pins(cmd_pins), .select_pins(sel),
        .lead_pulse(lead_pulse), .feedback_pulse(fb_pulse),
        .alarm_n(alarm_n), .drive_enable_n(enable_n),
        .ramped_reference(ref_hz), .op_state(op));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic final_report();
        if (err_total == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 6000) begin
            err_total++;
            final_report();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic pin(input logic [3:0] v, input int n);
        cmd_req <= cmd_pins_s'(v);
        cyc(n);
    endtask
    // response channels kept ready, so only address and data are held
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        forever begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        r = bresp;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        forever begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata;
        r = rresp;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        `CHK(d, e)
        `CHK(r, RESP_OKAY)
    endtask
    task automatic wait_ref(input logic [15:0] e);
        repeat (400) begin
            @(posedge clock);
            if (ref_hz === e) break;
        end
        `CHK(ref_hz, e)
    endtask
    task automatic s_strap();
        logic [3:0] v[3] = '{4'h0, 4'h8, 4'hC};
        op_state_e  s[3] = '{ST_RUN, ST_JOG, ST_RSTOP};
        for (int i = 0; i < 3; i++) begin
            cmd_req <= cmd_pins_s'(v[i]);
            nrst <= 1'b0;
            cyc(3);
            nrst <= 1'b1;
            cyc(2);
            `CHK(op, s[i])
        end
    endtask
    task automatic s_regs();
        logic [31:0] d;
        logic [1:0]  r;
        rchk(OFS_CONTROL, 32'h0);
        rchk(OFS_JOG_SP, 32'h32);
        rd(12'h100, d, r);
        `CHK(r, RESP_SLVERR)
        wr(OFS_RAMPED, 32'h1234, r);
        `CHK(r, RESP_SLVERR)
        rchk(OFS_RAMPED, 32'h0);
        rchk(OFS_IN_A, 32'hC);
        sel <= 2'b10;
        alarm_n <= 1'b0;
        cyc(2);
        rchk(OFS_IN_B, 32'h2);
        rchk(OFS_OUT_STAT, 32'h1);
        alarm_n <= 1'b1;
    endtask
    task automatic s_run();
        logic [1:0] r;
        wr(OFS_SCALED_SP, 32'h100, r);
        pin(4'h4, 2);
        pin(4'hC, 3);
        `CHK(op, ST_RUN)
        wait_ref(16'h0100);
        cyc(1);
        `CHK(enable_n, 1'b0)
        rchk(OFS_LEVEL_PCT, 32'd2);
        pin(4'h8, 3);
        `CHK(op, ST_RUN)
        pin(4'hE, 2);
        pin(4'hC, 3);
        `CHK(op, ST_RSTOP)
        `CHK(ref_hz != 16'h0000, 1'b1)
        wait_ref(16'h0000);
        cyc(2);
        `CHK(enable_n, 1'b1)
    endtask
    task automatic s_jog();
        pin(4'h8, 3);
        `CHK(op, ST_JOG)
        wait_ref(16'h0032);
        cyc(12);
        `CHK(ref_hz, 16'h0032)
        pin(4'hC, 3);
        `CHK(ref_hz, 16'h0000)
        `CHK(op, ST_RSTOP)
    endtask
    task automatic s_freq();
        lead_div <= 8'd5;
        fb_div <= 8'd1;
        cyc(700);
        rchk(OFS_LEAD_FREQ, 32'd3000);
        rchk(OFS_FB_FREQ, {16'h1, 16'd1500});
    endtask
    task automatic s_fstop();
        logic [1:0] r;
        wr(OFS_CONTROL, 32'h1, r);
        pin(4'h4, 2);
        pin(4'hC, 1);
        wait_ref(16'h0100);
        pin(4'hD, 1);
        pin(4'hC, 3);
        `CHK(op, ST_FSTOP)
        `CHK(ref_hz, 16'h0000)
        rchk(OFS_OP_STATE, 32'h1);
        cyc(3);
        `CHK(enable_n, 1'b0)
        fb_div <= 8'd0;
        cyc(700);
        `CHK(enable_n, 1'b1)
        pin(4'h4, 2);
        pin(4'hC, 3);
        `CHK(op, ST_RUN)
    endtask
    initial begin
        s_strap();
        s_regs();
        s_run();
        s_jog();
        s_freq();
        s_fstop();
        final_report();
    end
endmodule
`default_nettype wire

// [verilog/drive_pkg.sv]
`default_nettype none
package drive_pkg;
    localparam int CLOCK_HZ        = 125_000_000;
    localparam int WINDOW_MS       = 10;
    localparam int WINDOW_CYCLES   = CLOCK_HZ / 1000 * WINDOW_MS;
    localparam int HZ_PER_WINDOW   = 1000 / WINDOW_MS;
    localparam int RAMP_TICK_US    = 1000;
    localparam int RAMP_TICK_CYCLES =
        CLOCK_HZ / 1_000_000 * RAMP_TICK_US;
    localparam int FULL_SCALE_HZ   = 10000;
    localparam int PERCENT_FULL    = 100;
    localparam logic [15:0] DISPLAY_LIMIT = 16'h270F;
    localparam logic [15:0] DISPLAY_DIV   = 16'h000A;

    localparam logic [11:0] OFS_CONTROL   = 12'h000;
    localparam logic [11:0] OFS_JOG_SP    = 12'h004;
    localparam logic [11:0] OFS_ACCEL     = 12'h008;
    localparam logic [11:0] OFS_DECEL     = 12'h00C;
    localparam logic [11:0] OFS_SCALED_SP = 12'h010;
    localparam logic [11:0] OFS_RAMPED    = 12'h014;
    localparam logic [11:0] OFS_LEAD_FREQ = 12'h018;
    localparam logic [11:0] OFS_FB_FREQ   = 12'h01C;
    localparam logic [11:0] OFS_IN_A      = 12'h020;
    localparam logic [11:0] OFS_IN_B      = 12'h024;
    localparam logic [11:0] OFS_OUT_STAT  = 12'h028;
    localparam logic [11:0] OFS_LEVEL_PCT = 12'h02C;
    localparam logic [11:0] OFS_OP_STATE  = 12'h030;

    localparam int POLICY_BIT    = 0;
    localparam int DISP_FLAG_BIT = 16;

    localparam logic        POLICY_RESET   = 1'b0;
    localparam logic [15:0] JOG_SP_RESET   = 16'h0032;
    localparam logic [15:0] ACCEL_RESET    = 16'h0010;
    localparam logic [15:0] DECEL_RESET    = 16'h0010;
    localparam logic [15:0] SCALED_SP_RESET = 16'h0000;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {
        ST_RSTOP = 2'b00,
        ST_FSTOP = 2'b01,
        ST_RUN   = 2'b10,
        ST_JOG   = 2'b11
    } op_state_e;

    // pin levels: 1 = open (high), 0 = shorted to common
    typedef struct packed {
        logic run;
        logic jog;
        logic rstop;
        logic fstop;
    } cmd_pins_s;

    typedef struct packed {
        logic master_follower;
        logic setpoint_sel;
    } select_pins_s;
endpackage
`default_nettype wire

// [verilog/drive_state_ctrl.sv]
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
module drive_state_ctrl #(
    parameter int WINDOW_CYCLES_P = drive_pkg::WINDOW_CYCLES,
    parameter int RAMP_CYCLES_P   = drive_pkg::RAMP_TICK_CYCLES,
    parameter int FULL_SCALE_P    = drive_pkg::FULL_SCALE_HZ
) (
    input  wire logic                   clock,
    input  wire logic                   nrst,
    input  wire logic [11:0]            s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [11:0]            s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire drive_pkg::cmd_pins_s   cmd_pins,
    input  wire drive_pkg::select_pins_s select_pins,
    input  wire logic                   lead_pulse,
    input  wire logic                   feedback_pulse,
    input  wire logic                   alarm_n,
    output logic                        drive_enable_n,
    output logic [15:0]                 ramped_reference,
    output drive_pkg::op_state_e        op_state
);
    import drive_pkg::*;

    typedef struct packed {
        op_state_e   op;
        logic        booted;
        logic [31:0] ramp_cnt;
        logic [31:0] win_cnt;
        logic [15:0] ref_hz;
        logic        den_n;
        logic        policy;
        logic [15:0] jog_sp;
        logic [15:0] accel;
        logic [15:0] decel;
        logic [15:0] scaled_sp;
        logic [7:0]  pct;
        logic        aw_held;
        logic [11:0] aw_addr;
        logic        w_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
    } ctrl_s;

    ctrl_s       s;
    ctrl_s       next_s;
    logic        ramp_tick;
    logic        window;
    logic        jog_drop;
    logic [15:0] target;
    logic [16:0] gap;
    logic [15:0] freq [2];
    logic [1:0]  pulses;
    logic [31:0] rd_word;
    logic        rd_hit;
    logic        wr_hit;
    logic [31:0] pct_wide;

    assign pulses = {feedback_pulse, lead_pulse};

    generate
        for (genvar i = 0; i < 2; i++) begin : g_meter
            pulse_rate_meter #(
                .COUNT_W (10),
                .FREQ_W  (16)
            ) u_meter (
                .clock    (clock),
                .nrst     (nrst),
                .pulse_in (pulses[i]),
                .window   (window),
                .freq     (freq[i])
            );
        end
    endgenerate

    assign ramp_tick = s.ramp_cnt == 32'(RAMP_CYCLES_P - 1);
    assign window    = s.win_cnt == 32'(WINDOW_CYCLES_P - 1);

    // large values lose a digit and carry a decimal flag
    function automatic logic [31:0] show(input logic [15:0] f);
        if (f > DISPLAY_LIMIT) begin
            show = {15'h0000, 1'b1, f / DISPLAY_DIV};
        end else begin
            show = {16'h0000, f};
        end
    endfunction

    function automatic logic [15:0] put16(input logic [15:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0]  st);
        put16 = old;
        if (st[0]) begin
            put16[7:0] = d[7:0];
        end
        if (st[1]) begin
            put16[15:8] = d[15:8];
        end
    endfunction

    always_comb begin
        rd_hit  = 1'b1;
        rd_word = 32'h0000_0000;
        unique case (s_axi_araddr)
            OFS_CONTROL:   rd_word[POLICY_BIT] = s.policy;
            OFS_JOG_SP:    rd_word[15:0] = s.jog_sp;
            OFS_ACCEL:     rd_word[15:0] = s.accel;
            OFS_DECEL:     rd_word[15:0] = s.decel;
            OFS_SCALED_SP: rd_word[15:0] = s.scaled_sp;
            OFS_RAMPED:    rd_word = show(s.ref_hz);
            OFS_LEAD_FREQ: rd_word = show(freq[0]);
            OFS_FB_FREQ:   rd_word = show(freq[1]);
            OFS_IN_A:      rd_word[3:0] = cmd_pins;
            OFS_IN_B:      rd_word[1:0] = select_pins;
            OFS_OUT_STAT:  rd_word[1:0] = {alarm_n, s.den_n};
            OFS_LEVEL_PCT: rd_word[7:0] = s.pct;
            OFS_OP_STATE:  rd_word[1:0] = s.op;
            default:       rd_hit = 1'b0;
        endcase
    end

    // monitors are listed here and answer SLVERR, and writes to them change nothing
    always_comb begin
        unique case (s.aw_addr)
            OFS_CONTROL, OFS_JOG_SP, OFS_ACCEL, OFS_DECEL,
            OFS_SCALED_SP: wr_hit = 1'b1;
            OFS_RAMPED, OFS_LEAD_FREQ, OFS_FB_FREQ, OFS_IN_A,
            OFS_IN_B, OFS_OUT_STAT, OFS_LEVEL_PCT,
            OFS_OP_STATE: wr_hit = 1'b0;
            default: wr_hit = 1'b0;
        endcase
    end

    always_comb begin
        unique case (s.op)
            ST_RUN:  target = s.scaled_sp;
            ST_JOG:  target = s.jog_sp;
            ST_RSTOP, ST_FSTOP: target = 16'h0000;
        endcase
    end

    always_comb begin
        next_s = s;
        jog_drop = 1'b0;
        gap = 17'h00000;
        next_s.ramp_cnt = ramp_tick ? 32'h0 : s.ramp_cnt + 32'h1;
        next_s.win_cnt = window ? 32'h0 : s.win_cnt + 32'h1;

        // first cycle after reset samples the straps
        if (!s.booted) begin
            next_s.booted = 1'b1;
            if (!cmd_pins.run && !cmd_pins.rstop && !cmd_pins.fstop) begin
                next_s.op = ST_RUN;
            end else if (!cmd_pins.jog && !cmd_pins.rstop
                         && !cmd_pins.fstop) begin
                next_s.op = ST_JOG;
            end else begin
                next_s.op = ST_RSTOP;
            end
        end else if (cmd_pins.fstop) begin
            next_s.op = ST_FSTOP;
        end else if (cmd_pins.rstop) begin
            next_s.op = ST_RSTOP;
        end else if (s.op == ST_JOG) begin
            // run is ignored while jogging
            if (cmd_pins.jog) begin
                next_s.op = ST_RSTOP;
                jog_drop = 1'b1;
            end
        end else if (!cmd_pins.run && cmd_pins.jog) begin
            next_s.op = ST_RUN;
        end else if (!cmd_pins.jog && cmd_pins.run
                     && s.op != ST_RUN) begin
            next_s.op = ST_JOG;
        end

        // fast stop and jog release skip the ramp entirely
        if (next_s.op == ST_FSTOP || jog_drop) begin
            next_s.ref_hz = 16'h0000;
        end else if (ramp_tick) begin
            if (target > s.ref_hz) begin
                gap = {1'b0, target} - {1'b0, s.ref_hz};
                if (gap > {1'b0, s.accel}) begin
                    next_s.ref_hz = s.ref_hz + s.accel;
                end else begin
                    next_s.ref_hz = target;
                end
            end else if (target < s.ref_hz) begin
                gap = {1'b0, s.ref_hz} - {1'b0, target};
                if (gap > {1'b0, s.decel}) begin
                    next_s.ref_hz = s.ref_hz - s.decel;
                end else begin
                    next_s.ref_hz = target;
                end
            end
        end

        if (s.ref_hz != 16'h0000) begin
            next_s.den_n = 1'b0;
        end else if (!s.policy || freq[1] == 16'h0000) begin
            next_s.den_n = 1'b1;
        end

        if (pct_wide > 32'(PERCENT_FULL)) begin
            next_s.pct = 8'(PERCENT_FULL);
        end else begin
            next_s.pct = pct_wide[7:0];
        end

        if (s_axi_awvalid && !s.aw_held) begin
            next_s.aw_held = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s.w_held) begin
            next_s.w_held = 1'b1;
            next_s.w_data = s_axi_wdata;
            next_s.w_strb = s_axi_wstrb;
        end
        if (s.aw_held && s.w_held && !s.bvalid) begin
            next_s.aw_held = 1'b0;
            next_s.w_held = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
            unique case (s.aw_addr)
                OFS_CONTROL: begin
                    if (s.w_strb[0]) begin
                        next_s.policy = s.w_data[POLICY_BIT];
                    end
                end
                OFS_JOG_SP: next_s.jog_sp =
                    put16(s.jog_sp, s.w_data, s.w_strb);
                OFS_ACCEL: next_s.accel =
                    put16(s.accel, s.w_data, s.w_strb);
                OFS_DECEL: next_s.decel =
                    put16(s.decel, s.w_data, s.w_strb);
                OFS_SCALED_SP: next_s.scaled_sp =
                    put16(s.scaled_sp, s.w_data, s.w_strb);
                default: ;
            endcase
        end
        if (s.bvalid && s_axi_bready) begin
            next_s.bvalid = 1'b0;
        end

        if (s_axi_arvalid && !s.rvalid) begin
            next_s.rvalid = 1'b1;
            next_s.rdata = rd_word;
            next_s.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s.rvalid && s_axi_rready) begin
            next_s.rvalid = 1'b0;
        end
    end

    assign pct_wide = 32'(s.ref_hz) * 32'(PERCENT_FULL)
                      / 32'(FULL_SCALE_P);

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
            s.op <= ST_RSTOP;
            s.den_n <= 1'b1;
            s.policy <= POLICY_RESET;
            s.jog_sp <= JOG_SP_RESET;
            s.accel <= ACCEL_RESET;
            s.decel <= DECEL_RESET;
            s.scaled_sp <= SCALED_SP_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign s_axi_awready    = !s.aw_held;
    assign s_axi_wready     = !s.w_held;
    assign s_axi_bvalid     = s.bvalid;
    assign s_axi_bresp      = s.bresp;
    assign s_axi_arready    = !s.rvalid;
    assign s_axi_rvalid     = s.rvalid;
    assign s_axi_rdata      = s.rdata;
    assign s_axi_rresp      = s.rresp;
    assign drive_enable_n   = s.den_n;
    assign ramped_reference = s.ref_hz;
    assign op_state         = s.op;
endmodule
`default_nettype wire

// [verilog/pulse_rate_meter.sv]
`timescale 1ns/1ns
`default_nettype none
module pulse_rate_meter #(
    parameter int COUNT_W = 10,
    parameter int FREQ_W  = 16
) (
    input  wire logic              clock,
    input  wire logic              nrst,
    input  wire logic              pulse_in,
    input  wire logic              window,
    output logic [FREQ_W-1:0]      freq
);
    import drive_pkg::*;

    typedef struct packed {
        logic               prev;
        logic [COUNT_W-1:0] cnt;
        logic [FREQ_W-1:0]  freq;
    } meter_s;

    meter_s s;
    meter_s next_s;
    logic   rise;
    logic [31:0] prod;

    assign rise = pulse_in && !s.prev;
    assign prod = 32'(s.cnt) * 32'(HZ_PER_WINDOW);
    assign freq = s.freq;

    always_comb begin
        next_s = s;
        next_s.prev = pulse_in;
        if (window) begin
            // count of this window times HZ_PER_WINDOW, no averaging
            // clamp instead of wrapping when the result overflows
            if ((prod >> FREQ_W) != 32'h0000_0000) begin
                next_s.freq = '1;
            end else begin
                next_s.freq = FREQ_W'(prod);
            end
            next_s.cnt = COUNT_W'(rise);
        end else if (rise && s.cnt != '1) begin
            // saturate rather than wrap on overrange input
            next_s.cnt = s.cnt + COUNT_W'(1);
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule
`default_nettype wire
